/* hdl/cpg_consts.svh */
/*
 * Constants of the configuration port, pin group and watchdog block.
 * Assumes that it is included by bare name; the guard lets it be included more than once per compilation unit.
 */
`ifndef CPG_CONSTS_SVH
`define CPG_CONSTS_SVH

`define CPG_IDX_PORT 16'h002e
`define CPG_DAT_PORT 16'h002f
`define CPG_UNLOCK_KEY 8'h87
`define CPG_LOCK_KEY 8'haa
`define CPG_IDLE_READ 8'hff

`define CPG_REG_LDN 8'h07
`define CPG_REG_ACT 8'h30
`define CPG_REG_DIR 8'hf0
`define CPG_REG_DATA 8'hf1
`define CPG_REG_INV 8'hf2
`define CPG_REG_UNIT 8'hf5
`define CPG_REG_COUNT 8'hf6
`define CPG_REG_STAT 8'hf7

`define CPG_LDN_PINS 8'h09
`define CPG_LDN_WDT 8'h08
`define CPG_ACT_BIT 0
`define CPG_UNIT_BIT 3
`define CPG_STAT_BIT 0

`define CPG_RST_ZERO 8'h00
`define CPG_DIR_RST 8'hff
`define CPG_RST_PULSE 8'h10

`define CPG_CLK_NS 4
`define CPG_SEC_NS 1000000000
`define CPG_PRE_W 28
`define CPG_SEC_PER_MIN 6'h3c

`endif

/* hdl/cpg_pkg.sv */
/*
 * Types shared by the configuration port design files.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package cpg_pkg;
    typedef enum logic [1:0] {
        CPG_LOCKED,
        CPG_KEY1,
        CPG_OPEN
    } cpg_cfg_state_t;
endpackage
`default_nettype wire

/* hdl/cpg_tick.sv */
/*
 * Second and minute tick generator for the watchdog.
 * Assumes ref_clk is free running; sec_cyc is the number of clocks per second.
 */
`include "cpg_consts.svh"
`default_nettype none
module cpg_tick #(
    parameter logic [`CPG_PRE_W-1:0] sec_cyc = `CPG_PRE_W'(`CPG_SEC_NS / `CPG_CLK_NS)
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    output logic sec_tick,
    output logic min_tick
);
    logic [`CPG_PRE_W-1:0] pre_q;
    logic [`CPG_PRE_W-1:0] pre_d;
    logic [5:0] sec_q;
    logic [5:0] sec_d;
    logic sec_tick_d;
    logic min_tick_d;

    always_comb begin
        pre_d = pre_q + `CPG_PRE_W'(1);
        sec_d = sec_q;
        sec_tick_d = 1'b0;
        min_tick_d = 1'b0;
        if (pre_q >= sec_cyc - `CPG_PRE_W'(1)) begin
            pre_d = '0;
            sec_tick_d = 1'b1;
            sec_d = sec_q + 6'h01;
            if (sec_q >= `CPG_SEC_PER_MIN - 6'h01) begin
                sec_d = '0;
                min_tick_d = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= '0;
            sec_q <= '0;
            sec_tick <= 1'b0;
            min_tick <= 1'b0;
        end else begin
            pre_q <= pre_d;
            sec_q <= sec_d;
            sec_tick <= sec_tick_d;
            min_tick <= min_tick_d;
        end
    end
endmodule
`default_nettype wire

/* hdl/cpg_top.sv */
/*
 * Configuration port with an eight pin group and a watchdog behind an
 * index/data port pair.
 * Assumes the host I/O cycle arrives synchronous to ref_clk as one-cycle
 * write or read strobes with a 16-bit port address.
 */
`include "cpg_consts.svh"
`default_nettype none
module cpg_top #(
    parameter logic [`CPG_PRE_W-1:0] sec_cyc = `CPG_PRE_W'(`CPG_SEC_NS / `CPG_CLK_NS)
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    output logic io_rvalid,
    input wire logic [7:0] pin_in,
    output logic [7:0] pin_out,
    output logic [7:0] pin_oe,
    output logic sys_reset
);
    cpg_pkg::cpg_cfg_state_t cfg_q;
    cpg_pkg::cpg_cfg_state_t cfg_d;
    logic [7:0] index_q;
    logic [7:0] index_d;
    logic [7:0] ldn_q;
    logic [7:0] ldn_d;
    logic [7:0] act_pins_q;
    logic [7:0] act_pins_d;
    logic [7:0] act_wdt_q;
    logic [7:0] act_wdt_d;
    logic [7:0] dir_q;
    logic [7:0] dir_d;
    logic [7:0] data_q;
    logic [7:0] data_d;
    logic [7:0] inv_q;
    logic [7:0] inv_d;
    logic [7:0] unit_q;
    logic [7:0] unit_d;
    logic [7:0] count_q;
    logic [7:0] count_d;
    logic fired_q;
    logic fired_d;
    logic [7:0] pulse_q;
    logic [7:0] pulse_d;
    logic [7:0] rdata_d;
    logic rvalid_d;
    logic [7:0] pin_out_d;
    logic [7:0] pin_oe_d;
    logic sys_reset_d;
    logic sec_tick;
    logic min_tick;
    logic unit_tick;
    logic idx_wr;
    logic dat_wr;
    logic dat_rd;
    logic sel_pins;
    logic sel_wdt;
    logic [7:0] pin_view;
    logic count_wr;
    logic stat_clr;
    logic expire;
    logic [7:0] pins_rdata;
    logic [7:0] wdt_rdata;

    // Minute ticks are derived from second ticks, so both units share one prescaler.
    cpg_tick #(
        .sec_cyc(sec_cyc)
    ) u_tick (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sec_tick(sec_tick),
        .min_tick(min_tick)
    );

    // Data port accesses only count while configuration is unlocked.
    assign idx_wr = io_wr && (io_addr == `CPG_IDX_PORT);
    assign dat_wr = io_wr && (io_addr == `CPG_DAT_PORT) && (cfg_q == cpg_pkg::CPG_OPEN);
    assign dat_rd = io_rd && (io_addr == `CPG_DAT_PORT) && (cfg_q == cpg_pkg::CPG_OPEN);
    assign sel_pins = (ldn_q == `CPG_LDN_PINS);
    assign sel_wdt = (ldn_q == `CPG_LDN_WDT);
    assign unit_tick = unit_q[`CPG_UNIT_BIT] ? min_tick : sec_tick;

    // Watchdog write strobes, qualified by the watchdog being the selected device; expiry is not qualified by it.
    assign count_wr = dat_wr && sel_wdt && (index_q == `CPG_REG_COUNT);
    assign stat_clr = dat_wr && sel_wdt && (index_q == `CPG_REG_STAT) && io_wdata[`CPG_STAT_BIT];
    assign expire = act_wdt_q[`CPG_ACT_BIT] && unit_tick && (count_q == 8'h01) && !count_wr;

    // Direction resets to all inputs, so no pin is driven before software has set it up.
    // Per-pin value as software sees it: the pad for inputs, the latch for outputs, both through inversion.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            assign pin_view[gi] = (dir_q[gi] ? pin_in[gi] : data_q[gi]) ^ inv_q[gi];
            assign pin_oe_d[gi] = act_pins_q[`CPG_ACT_BIT] && !dir_q[gi];
            assign pin_out_d[gi] = pin_oe_d[gi] && (data_q[gi] ^ inv_q[gi]);
        end
    endgenerate

    // Unlock sequence and index latch.
    // A wrong second key drops back to locked, so a lone key byte never opens the port.
    // The relock byte is not latched as an index, so the last index survives a relock.
    always_comb begin
        cfg_d = cfg_q;
        index_d = index_q;
        if (idx_wr) begin
            case (cfg_q)
                cpg_pkg::CPG_LOCKED: begin
                    if (io_wdata == `CPG_UNLOCK_KEY) begin
                        cfg_d = cpg_pkg::CPG_KEY1;
                    end
                end
                cpg_pkg::CPG_KEY1: begin
                    cfg_d = (io_wdata == `CPG_UNLOCK_KEY) ? cpg_pkg::CPG_OPEN : cpg_pkg::CPG_LOCKED;
                end
                cpg_pkg::CPG_OPEN: begin
                    if (io_wdata == `CPG_LOCK_KEY) begin
                        cfg_d = cpg_pkg::CPG_LOCKED;
                    end else begin
                        index_d = io_wdata;
                    end
                end
                default: begin
                    cfg_d = cpg_pkg::CPG_LOCKED;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= cpg_pkg::CPG_LOCKED;
            index_q <= `CPG_RST_ZERO;
        end else begin
            cfg_q <= cfg_d;
            index_q <= index_d;
        end
    end

    // Register writes through the data port.
    // Pin registers take writes only while the pin group is selected, watchdog registers likewise.
    always_comb begin
        ldn_d = ldn_q;
        act_pins_d = act_pins_q;
        act_wdt_d = act_wdt_q;
        dir_d = dir_q;
        data_d = data_q;
        inv_d = inv_q;
        unit_d = unit_q;
        if (dat_wr) begin
            case (index_q)
                `CPG_REG_LDN: ldn_d = io_wdata;
                `CPG_REG_ACT: begin
                    if (sel_pins) begin
                        act_pins_d = io_wdata;
                    end else if (sel_wdt) begin
                        act_wdt_d = io_wdata;
                    end
                end
                `CPG_REG_DIR: begin
                    if (sel_pins) begin
                        dir_d = io_wdata;
                    end
                end
                `CPG_REG_DATA: begin
                    if (sel_pins) begin
                        data_d = io_wdata;
                    end
                end
                `CPG_REG_INV: begin
                    if (sel_pins) begin
                        inv_d = io_wdata;
                    end
                end
                `CPG_REG_UNIT: begin
                    if (sel_wdt) begin
                        unit_d = io_wdata;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ldn_q <= `CPG_RST_ZERO;
            act_pins_q <= `CPG_RST_ZERO;
            act_wdt_q <= `CPG_RST_ZERO;
            dir_q <= `CPG_DIR_RST;
            data_q <= `CPG_RST_ZERO;
            inv_q <= `CPG_RST_ZERO;
            unit_q <= `CPG_RST_ZERO;
        end else begin
            ldn_q <= ldn_d;
            act_pins_q <= act_pins_d;
            act_wdt_q <= act_wdt_d;
            dir_q <= dir_d;
            data_q <= data_d;
            inv_q <= inv_d;
            unit_q <= unit_d;
        end
    end

    // Watchdog countdown, expiry flag and reset pulse.
    // The unit prescaler runs free, so the first unit after a load may be short by up to one unit.
    always_comb begin
        count_d = count_q;
        fired_d = fired_q;
        pulse_d = pulse_q;
        if (pulse_q != `CPG_RST_ZERO) begin
            pulse_d = pulse_q - 8'h01;
        end
        // A service write that lands on the last unit tick wins, so the system keeps running.
        if (count_wr) begin
            count_d = io_wdata;
        end else if (act_wdt_q[`CPG_ACT_BIT] && unit_tick && count_q != `CPG_RST_ZERO) begin
            count_d = count_q - 8'h01;
        end
        if (expire) begin
            pulse_d = `CPG_RST_PULSE;
        end
        // A clear written in the same cycle as an expiry loses to the expiry.
        if (expire) begin
            fired_d = 1'b1;
        end else if (stat_clr) begin
            fired_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= `CPG_RST_ZERO;
            fired_q <= 1'b0;
            pulse_q <= `CPG_RST_ZERO;
        end else begin
            count_q <= count_d;
            fired_q <= fired_d;
            pulse_q <= pulse_d;
        end
    end

    // Read data per device; registers of a device that is not selected read as zero.
    always_comb begin
        pins_rdata = `CPG_RST_ZERO;
        wdt_rdata = `CPG_RST_ZERO;
        case (index_q)
            `CPG_REG_ACT: begin
                pins_rdata = act_pins_q;
                wdt_rdata = act_wdt_q;
            end
            `CPG_REG_DIR: pins_rdata = dir_q;
            `CPG_REG_DATA: pins_rdata = pin_view;
            `CPG_REG_INV: pins_rdata = inv_q;
            `CPG_REG_UNIT: wdt_rdata = unit_q;
            `CPG_REG_COUNT: wdt_rdata = count_q;
            `CPG_REG_STAT: wdt_rdata = {7'h00, fired_q};
            default: begin
            end
        endcase
    end

    // Both ports always answer a read; a locked port answers all ones, as an absent device would.
    always_comb begin
        rdata_d = `CPG_IDLE_READ;
        rvalid_d = io_rd && ((io_addr == `CPG_IDX_PORT) || (io_addr == `CPG_DAT_PORT));
        if (io_rd && io_addr == `CPG_IDX_PORT && cfg_q == cpg_pkg::CPG_OPEN) begin
            rdata_d = index_q;
        end
        if (dat_rd) begin
            if (index_q == `CPG_REG_LDN) begin
                rdata_d = ldn_q;
            end else if (sel_pins) begin
                rdata_d = pins_rdata;
            end else if (sel_wdt) begin
                rdata_d = wdt_rdata;
            end else begin
                rdata_d = `CPG_RST_ZERO;
            end
        end
    end

    // The reset request leaves from the same edge that loads the pulse counter.
    always_comb begin
        sys_reset_d = (pulse_d != `CPG_RST_ZERO);
    end

    // Every output leaves from a flop, so pin changes trail the register write by one clock; reset leaves with the pulse counter load.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            io_rdata <= `CPG_RST_ZERO;
            io_rvalid <= 1'b0;
            pin_out <= `CPG_RST_ZERO;
            pin_oe <= `CPG_RST_ZERO;
            sys_reset <= 1'b0;
        end else begin
            io_rdata <= rdata_d;
            io_rvalid <= rvalid_d;
            pin_out <= pin_out_d;
            pin_oe <= pin_oe_d;
            sys_reset <= sys_reset_d;
        end
    end
endmodule
`default_nettype wire

/* dv/cpg_top_assertions.sv */
/*
 * Port checker for the configuration port, pin group and watchdog.
 * Assumes it is bound to cpg_top and sees only that module's ports.
 */
`include "cpg_consts.svh"
`default_nettype none
module cpg_top_assertions (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [15:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic io_rvalid,
    input wire logic [7:0] pin_in,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic sys_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic port_hit;
    assign port_hit = io_addr == `CPG_IDX_PORT || io_addr == `CPG_DAT_PORT;
    sequence s_read_taken;
        io_rd && port_hit;
    endsequence
    sequence s_pulse_high;
        sys_reset [*8] ##1 sys_reset [*8];
    endsequence
    a_read_answered: assert property (s_read_taken |=> io_rvalid)
        else $error("read not answered");
    a_answer_cause: assert property (io_rvalid |-> $past(io_rd) && $past(port_hit))
        else $error("answer without read");
    a_answer_single: assert property (s_read_taken ##1 !io_rd |=> !io_rvalid)
        else $error("answer longer than one cycle");
    a_rdata_idle: assert property (!io_rvalid && $past(arst_n) |-> io_rdata == `CPG_IDLE_READ)
        else $error("read data not idle without answer");
    a_out_gated: assert property ((pin_out & ~pin_oe) == 8'h00)
        else $error("input pin driven");
    a_oe_cause: assert property ($changed(pin_oe) |-> $past(io_wr, 2))
        else $error("direction changed without write");
    a_out_cause: assert property ($changed(pin_out) |-> $past(io_wr, 2))
        else $error("drive level changed without write");
    a_pulse_len: assert property ($rose(sys_reset) |-> s_pulse_high ##1 !sys_reset)
        else $error("system reset pulse length wrong");
endmodule
bind cpg_top cpg_top_assertions i_cpg_top_assertions (.ref_clk(ref_clk), .arst_n(arst_n),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .sys_reset(sys_reset));
`default_nettype wire

/* dv/cpg_top_bench.sv */
/*
 * Self-checking bench for cpg_top: port access, pins and watchdog.
 * Assumes a ten clock second so that minute counts stay short.
 */
`include "cpg_consts.svh"
`default_nettype none
module cpg_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SEC = 10;
    logic ref_clk = 1'b0, arst_n = 1'b0, io_wr = 1'b0, io_rd = 1'b0, io_rvalid, sys_reset;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0] io_wdata = 8'h00, pin_in = 8'h3c, io_rdata, pin_out, pin_oe, rd_val;
    int bad_count = 0, n_compared = 0, cyc = 0, n;
    cpg_top #(.sec_cyc(`CPG_PRE_W'(SEC))) i_cpg_top (.ref_clk(ref_clk), .arst_n(arst_n),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .io_rvalid(io_rvalid), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .sys_reset(sys_reset));
    initial begin
        forever #2 ref_clk = ~ref_clk;
    end
    // The two minute countdown dominates the run, so the ceiling sits well above it.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            bad_count++;
            tally_and_finish();
        end
    end
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_win(input int got, input int lo, input int hi, input string what);
        n_compared++;
        if (got < lo || got > hi) begin
            bad_count++;
            $display("unexpected at %0t: %s took %0d cycles", $time, what, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        io_addr = a;
        io_wdata = d;
        io_wr = 1'b1;
        @(negedge ref_clk);
        io_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a);
        @(negedge ref_clk);
        io_addr = a;
        io_rd = 1'b1;
        @(negedge ref_clk);
        io_rd = 1'b0;
        // The answer stands only in the cycle after the read edge, so it is looked at here.
        chk8({7'h00, io_rvalid}, 8'h01, "read answer");
        rd_val = io_rdata;
    endtask
    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        wr(`CPG_IDX_PORT, idx);
        wr(`CPG_DAT_PORT, d);
    endtask
    task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp, input string what);
        wr(`CPG_IDX_PORT, idx);
        rd(`CPG_DAT_PORT);
        chk8(rd_val, exp, what);
    endtask
    task automatic wait_expiry(input int lo, input int hi, input string what);
        n = 0;
        while (sys_reset !== 1'b1 && n < hi + 20) begin
            @(negedge ref_clk);
            n++;
        end
        chk_win(n, lo, hi, what);
        repeat (20) @(negedge ref_clk);
    endtask
    task automatic t_locked();
        reg_wr(8'hf0, 8'h00);
        reg_rd(8'hf0, 8'hff, "locked read");
        chk8(pin_oe, 8'h00, "locked pins");
        $display("test locked done");
    endtask
    task automatic t_pins();
        wr(`CPG_IDX_PORT, 8'h87);
        wr(`CPG_IDX_PORT, 8'h87);
        reg_wr(8'h07, 8'h09);
        reg_wr(8'hf0, 8'h0f);
        reg_wr(8'hf1, 8'ha5);
        chk8(pin_oe, 8'h00, "enable before activate");
        reg_wr(8'h30, 8'h01);
        @(negedge ref_clk);
        chk8(pin_oe, 8'hf0, "direction");
        chk8(pin_out, 8'ha0, "drive level");
        reg_wr(8'hf2, 8'h30);
        @(negedge ref_clk);
        chk8(pin_out, 8'h90, "inverted drive");
        reg_rd(8'hf0, 8'h0f, "direction readback");
        reg_rd(8'hf1, 8'h9c, "pin readback");
        $display("test pins done");
    endtask
    task automatic t_wdog();
        reg_wr(8'h07, 8'h08);
        reg_wr(8'h30, 8'h01);
        reg_wr(8'hf5, 8'h00);
        reg_wr(8'hf6, 8'h05);
        wait_expiry(4 * SEC - 2, 5 * SEC + 3, "second countdown");
        reg_rd(8'hf6, 8'h00, "spent count");
        reg_rd(8'hf7, 8'h01, "expiry status");
        reg_wr(8'hf7, 8'h01);
        reg_rd(8'hf7, 8'h00, "status cleared");
        reg_wr(8'hf6, 8'h03);
        repeat (15) @(negedge ref_clk);
        reg_wr(8'hf6, 8'h03);
        wait_expiry(2 * SEC - 2, 3 * SEC + 3, "serviced countdown");
        reg_wr(8'hf5, 8'h08);
        reg_wr(8'hf6, 8'h02);
        wait_expiry(60 * SEC - 2, 120 * SEC + 3, "minute countdown");
        $display("test watchdog done");
    endtask
    task automatic t_relock();
        rd(`CPG_IDX_PORT);
        chk8(rd_val, 8'hf6, "index readback");
        wr(`CPG_IDX_PORT, 8'haa);
        reg_rd(8'hf5, 8'hff, "relocked read");
        $display("test relock done");
    endtask
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge ref_clk);
        arst_n = 1'b1;
        t_locked();
        t_pins();
        t_wdog();
        t_relock();
        tally_and_finish();
    end
endmodule
`default_nettype wire
